// [core/rss_regs.vh]
`ifndef RSS_REGS_VH
`define RSS_REGS_VH
// ==========================================
// Register offsets
`define RSS_OFS_CAUSE 8'h00
`define RSS_OFS_FORCE 8'h01
// ==========================================
// Cause register bit positions
`define RSS_BIT_POWER_ON 7
`define RSS_BIT_PIN 6
`define RSS_BIT_WATCHDOG 5
`define RSS_BIT_ILL_OPCODE 4
`define RSS_BIT_ILL_ADDRESS 3
`define RSS_BIT_CLOCK_LOSS 2
`define RSS_BIT_LOW_VOLTAGE 1
`define RSS_BIT_FORCE 0
// ==========================================
// Reset values and watchdog service keys
`define RSS_CAUSE_RESET 8'h82
`define RSS_FORCE_READ 8'h00
`define RSS_KEY_FIRST 8'h55
`define RSS_KEY_SECOND 8'haa
`endif

// [core/rss_reset_source_status.v]
// Operation
// [RL1] The cause register offers read-only flags naming the source of the latest reset.
// [RL2] A reset forced by the debug host leaves every cause flag cleared.
// [RL3] With the watchdog enabled, a cause-register write other than 0x55 or 0xaa trips it.
// [RL4] Writing 0x55 then 0xaa restarts the watchdog and leaves the stored flags alone.
// [RL5] At reset entry each active source sets its flag and each inactive one clears it; the code keeps the old power-on flag on a low-voltage-only reset.
// [RL6] Power-on sets bit 7 and also bit 1.
// [RL7] An enabled low-voltage trip resets and sets bit 1, keeping the power-on flag.
// [RL8] A low level on the external reset pin sets bit 6.
// [RL9] A watchdog timeout sets bit 5 and is blocked while the watchdog is disabled.
// [RL10] Illegal opcodes, stop without permit and background without permit set bit 4.
// [RL11] Access to an unimplemented address sets bit 3.
// [RL12] Loss of the external clock sets bit 2.
// [RL13] User-program writes to the force register are ignored; only debug writes count.
// [RL14] The force register always reads zero.
// [RL15] A debug write of one to force bit 0 forces a full reset.
// [RL16] The debug host writes the force register with a background memory write command.
// [RL17] Cause bit 0 reads zero and flags change only at reset entry.
`timescale 1ns/1ps
`include "rss_regs.vh"

module rss_reset_source_status
(
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire power_on_event,
  input wire pin_reset_n,
  input wire watchdog_timeout,
  input wire watchdog_enable,
  input wire illegal_opcode_exec,
  input wire stop_exec,
  input wire stop_permit,
  input wire background_instruction,
  input wire background_mode_permit,
  input wire illegal_address_access,
  input wire clock_loss_event,
  input wire low_voltage_event,
  input wire low_voltage_reset_enable,
  input wire bus_wr,
  input wire bus_rd,
  input wire bus_debug,
  input wire [7:0] bus_addr,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  output reg watchdog_restart,
  output reg system_reset
);

  // ==========================================
  // Fixed values
  localparam [7:0] cause_init = `RSS_CAUSE_RESET;
  localparam [7:0] force_read = `RSS_FORCE_READ;
  localparam [7:0] key_first = `RSS_KEY_FIRST;
  localparam [7:0] key_second = `RSS_KEY_SECOND;
  localparam [7:0] ofs_cause = `RSS_OFS_CAUSE;
  localparam [7:0] ofs_force = `RSS_OFS_FORCE;
  localparam integer flag_count = 8;

  // ==========================================
  // Register state
  reg [7:0] reset_cause_register;
  reg key_armed;

  // ==========================================
  // Bus decode nets
  wire cause_hit;
  wire force_hit;
  wire cause_wr;
  wire force_wr_debug;
  wire key_first_seen;
  wire key_second_seen;
  wire key_other;

  // ==========================================
  // Source nets
  wire por_src;
  wire pin_src;
  reg wdog_timeout_src;
  reg wdog_key_src;
  wire wdog_src;
  wire opcode_src;
  reg stop_src;
  reg background_instruction_src;
  wire illegal_opcode_flag_src;
  wire illegal_address_flag_src;
  wire loc_src;
  reg lvd_src;
  wire force_src;
  wire [7:0] src_vec;
  wire flag_src;
  wire any_src;
  wire reset_entry;
  wire other_than_lvd;
  wire lvd_only;

  // ==========================================
  // Next-state nets and variables
  wire [7:0] next_cause;
  reg next_key_armed;
  reg next_watchdog_restart;
  reg next_system_reset;
  reg [7:0] next_rdata;

  // ==========================================
  // Bus decode
  assign cause_hit = (bus_addr == ofs_cause);
  assign force_hit = (bus_addr == ofs_force);
  // Debug-side writes to the cause address are not a watchdog service
  assign cause_wr = bus_wr && !bus_debug && cause_hit;
  // User-program writes never reach the force bit
  assign force_wr_debug = bus_wr && bus_debug && force_hit; // [RL13]
  assign key_first_seen = cause_wr && (bus_wdata == key_first);
  assign key_second_seen = cause_wr && (bus_wdata == key_second);
  // Any value outside the two keys counts as a failed service
  assign key_other = cause_wr && !key_first_seen && !key_second_seen; // [RL3]

  // ==========================================
  // Plain reset sources
  assign por_src = power_on_event;
  assign pin_src = !pin_reset_n; // [RL8]
  assign opcode_src = illegal_opcode_exec;
  assign illegal_address_flag_src = illegal_address_access; // [RL11]
  assign loc_src = clock_loss_event; // [RL12]
  assign force_src = force_wr_debug && bus_wdata[`RSS_BIT_FORCE]; // [RL15]

  // ==========================================
  // Gated reset sources
  always @*
  begin
    wdog_timeout_src = 1'b0;
    wdog_key_src = 1'b0;
    stop_src = 1'b0;
    background_instruction_src = 1'b0;
    lvd_src = 1'b0;
    // Gated by the enable, so a stray write cannot reset a part whose watchdog is off
    if (watchdog_enable)
    begin
      wdog_timeout_src = watchdog_timeout; // [RL9]
      wdog_key_src = key_other; // [RL3]
    end
    // Stop is only an illegal opcode while it is not permitted
    if (!stop_permit)
    begin
      stop_src = stop_exec; // [RL10]
    end
    // Same for the background instruction
    if (!background_mode_permit)
    begin
      background_instruction_src = background_instruction; // [RL10]
    end
    // A low supply only resets when that reset is enabled
    if (low_voltage_reset_enable)
    begin
      lvd_src = low_voltage_event; // [RL7]
    end
  end
  assign wdog_src = wdog_timeout_src || wdog_key_src;
  assign illegal_opcode_flag_src = opcode_src || stop_src || background_instruction_src; // [RL10]

  // ==========================================
  // Source vector in flag order
  assign src_vec[`RSS_BIT_POWER_ON] = por_src; // [RL6]
  assign src_vec[`RSS_BIT_PIN] = pin_src; // [RL8]
  assign src_vec[`RSS_BIT_WATCHDOG] = wdog_src; // [RL9]
  assign src_vec[`RSS_BIT_ILL_OPCODE] = illegal_opcode_flag_src; // [RL10]
  assign src_vec[`RSS_BIT_ILL_ADDRESS] = illegal_address_flag_src; // [RL11]
  assign src_vec[`RSS_BIT_CLOCK_LOSS] = loc_src; // [RL12]
  // Power-on also marks low voltage, since supply was still ramping
  assign src_vec[`RSS_BIT_LOW_VOLTAGE] = lvd_src || por_src; // [RL6]
  // The forced reset owns no flag, so it alone leaves every flag clear
  assign src_vec[`RSS_BIT_FORCE] = 1'b0; // [RL2] [RL17]
  assign flag_src = |src_vec;
  // Force counts as a source but carries no flag of its own
  assign any_src = flag_src || force_src;

  // ==========================================
  // Reset entry
  // Only the first cycle of a reset is captured; later sources are not merged
  assign reset_entry = any_src && !system_reset; // [RL5]
  assign other_than_lvd = por_src || pin_src || wdog_src || illegal_opcode_flag_src || illegal_address_flag_src || loc_src;
  assign lvd_only = lvd_src && !other_than_lvd;

  // ==========================================
  // Per-flag next value
  genvar b;
  generate
    for (b = 0; b < flag_count; b = b + 1)
    begin : g_flag
      if (b == `RSS_BIT_POWER_ON)
      begin : g_keep
        // Low-voltage alone keeps the old power-on flag
        assign next_cause[b] = lvd_only ? reset_cause_register[b] : src_vec[b]; // [RL7]
      end
      else
      begin : g_take
        // Every other flag simply follows its source at entry
        assign next_cause[b] = src_vec[b]; // [RL5]
      end
    end
  endgenerate

  // ==========================================
  // Watchdog service and reset request
  always @*
  begin
    next_key_armed = key_armed;
    next_watchdog_restart = 1'b0;
    next_system_reset = any_src;
    if (reset_entry)
    begin
      // A reset drops a half-written key
      next_key_armed = 1'b0;
    end
    else if (cause_wr)
    begin
      // Any cause write other than the first key disarms
      next_key_armed = key_first_seen;
      next_watchdog_restart = key_armed && key_second_seen; // [RL4]
    end
  end

  // ==========================================
  // Read data
  always @*
  begin
    next_rdata = bus_rdata;
    if (bus_rd)
    begin
      if (cause_hit)
      begin
        next_rdata = reset_cause_register; // [RL1]
      end
      else
      begin
        // Force register and unused addresses read zero
        next_rdata = force_read; // [RL14]
      end
    end
  end

  // ==========================================
  // Cause flags
  // Written only at reset entry; the bus can never alter them
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      reset_cause_register <= cause_init; // [RL6]
    end
    else if (clk_en)
    begin
      if (reset_entry)
      begin
        reset_cause_register <= next_cause; // [RL17]
      end
    end
    else
    begin
      reset_cause_register <= reset_cause_register;
    end
  end

  // ==========================================
  // Key state
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      key_armed <= 1'b0;
    end
    else if (clk_en)
    begin
      key_armed <= next_key_armed; // [RL4]
    end
    else
    begin
      key_armed <= key_armed;
    end
  end

  // ==========================================
  // Watchdog restart pulse
  // One cycle wide so the timer is cleared exactly once per key pair
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      watchdog_restart <= 1'b0;
    end
    else if (clk_en)
    begin
      watchdog_restart <= next_watchdog_restart; // [RL4]
    end
    else
    begin
      watchdog_restart <= watchdog_restart;
    end
  end

  // ==========================================
  // Reset request
  // Registered, so the request lags its source by one cycle
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      system_reset <= 1'b0;
    end
    else if (clk_en)
    begin
      system_reset <= next_system_reset; // [RL5]
    end
    else
    begin
      system_reset <= system_reset;
    end
  end

  // ==========================================
  // Read data register
  // Holds until the next read, so the host may sample late
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      bus_rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      bus_rdata <= next_rdata; // [RL1]
    end
    else
    begin
      bus_rdata <= bus_rdata;
    end
  end
endmodule // rss_reset_source_status

// [verif/rss_checker.sv]
`timescale 1ns/1ps
module rss_checker(input wire ref_clk, rst, clk_en, bus_wr, bus_rd, bus_debug, pin_reset_n,
  watchdog_enable, clock_loss_event, watchdog_restart, system_reset,
  input wire [7:0] bus_addr, bus_wdata, bus_rdata);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || !clk_en);
  wire cw = bus_wr && !bus_debug && bus_addr == 8'h00;
  wire bad = cw && watchdog_enable && !(bus_wdata inside {8'h55, 8'haa});
  wire fw = bus_wr && bus_debug && bus_addr == 8'h01 && bus_wdata[0];
  sequence k1; cw && bus_wdata == 8'h55; endsequence
  sequence k2; cw && bus_wdata == 8'haa; endsequence
  AST_KEY: assert property (k1 ##1 !bus_wr ##1 k2 |=> watchdog_restart) else $error("key");
  AST_ONE: assert property (watchdog_restart |=> !watchdog_restart) else $error("pulse");
  AST_BAD: assert property (bad |=> system_reset) else $error("bad key");
  AST_FRC: assert property (fw |=> system_reset) else $error("force");
  AST_FRD: assert property (bus_rd && bus_addr == 8'h01 |=> !bus_rdata) else $error("rd");
  AST_BT0: assert property (bus_rd |=> !bus_rdata[0]) else $error("bit 0");
  AST_PIN: assert property (!pin_reset_n |=> system_reset) else $error("pin");
  AST_LOC: assert property (clock_loss_event |=> system_reset) else $error("clock");
endmodule // rss_checker

// [verif/rss_host.sv]
`timescale 1ns/1ps
module rss_host(input wire ref_clk, output reg act = 0, output reg [7:0] wd = 0);
  // Byte write of the force register; data inverted once released
  task frc;
    @(posedge ref_clk) {act, wd} <= 9'h101;
    @(posedge ref_clk) {act, wd} <= 9'h0fe;
  endtask
endmodule // rss_host

// [verif/rss_reset_source_status_tb.sv]
`timescale 1ns/1ps
`define CK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module rss_reset_source_status_tb;
  reg ref_clk = 0, rst = 1, rd = 0, wr = 0;
  reg en = 1, wde = 1, sp = 0, bp = 0, lve = 1;
  reg [8:0] s = 9'h010;
  reg [7:0] ad = 8'h00, wd = 8'h00;
  wire ha, rs, sr;
  wire [7:0] hd, q;
  int error_cnt = 0, cmp_count = 0;
  always #12.5 ref_clk = ~ref_clk;
  rss_host rss_host_i(.ref_clk(ref_clk), .act(ha), .wd(hd));
  rss_reset_source_status rss_reset_source_status_i(.ref_clk(ref_clk), .rst(rst), .clk_en(en),
    .power_on_event(s[8]), .pin_reset_n(s[4]), .watchdog_timeout(s[3]), .watchdog_enable(wde),
    .illegal_opcode_exec(s[2]), .stop_exec(s[5]), .stop_permit(sp), .background_instruction(s[6]),
    .background_mode_permit(bp), .illegal_address_access(s[1]), .clock_loss_event(s[0]),
    .low_voltage_event(s[7]), .low_voltage_reset_enable(lve), .bus_wr(wr | ha), .bus_rd(rd),
    .bus_debug(ha), .bus_addr(ha ? 8'h01 : ad), .bus_wdata(ha ? hd : wd), .bus_rdata(q),
    .watchdog_restart(rs), .system_reset(sr));
  task w(input [7:0] a, d);
    @(posedge ref_clk) {wr, ad, wd} <= {1'b1, a, d};
    @(posedge ref_clk) wr <= 1'b0;
  endtask
  task r(input [7:0] a, e);
    @(posedge ref_clk) {rd, ad} <= {1'b1, a};
    @(posedge ref_clk) rd <= 1'b0;
    @(posedge ref_clk) #1 `CK(q, e)
  endtask
  // Each source alone for one cycle; the pin sits at bit 4 and is active low
  task t_src;
    for (int i = 0; i < 9; i++) begin
      @(posedge ref_clk) s <= 9'h010 ^ (9'h001 << i);
      @(posedge ref_clk) s <= 9'h010;
      #1 `CK(sr, 1'b1)
      r(8'h00, i < 5 ? 8'h04 << i : i < 7 ? 8'h10 : i < 8 ? 8'h02 : 8'h82);
    end
    // Low voltage after power-on must keep the power-on flag
    @(posedge ref_clk) s <= 9'h090;
    @(posedge ref_clk) s <= 9'h010;
    #1 `CK(sr, 1'b1)
    r(8'h00, 8'h82);
  endtask
  task t_bus;
    w(8'h00, 8'h55);
    w(8'h00, 8'haa);
    #1 `CK(rs, 1'b1)
    r(8'h00, 8'h82);
    w(8'h01, 8'h01);
    #1 `CK(sr, 1'b0)
    r(8'h01, 8'h00);
    rss_host_i.frc;
    #1 `CK(sr, 1'b1)
    r(8'h00, 8'h00);
    w(8'h00, 8'h12);
    #1 `CK(sr, 1'b1)
  endtask
  // Enables off and permits on: only the pin (i == 4) may reset
  task t_gate;
    @(posedge ref_clk) {wde, sp, bp, lve} <= 4'b0110;
    for (int i = 3; i < 8; i++) begin
      @(posedge ref_clk) s <= 9'h010 ^ (9'h001 << i);
      @(posedge ref_clk) s <= 9'h010;
      #1 `CK(sr, i == 4)
    end
    w(8'h00, 8'h12);
    #1 `CK(sr, 1'b0)
    @(posedge ref_clk) {en, s} <= 10'h000;
    @(posedge ref_clk) s <= 9'h010;
    @(posedge ref_clk) {en, wde, sp, bp, lve} <= 5'h19;
    #1 `CK(sr, 1'b0)
    r(8'h00, 8'h40);
  endtask
  // Reset in mid-run reloads power-on flags and drops a half key
  task t_rst;
    w(8'h00, 8'h55);
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1 `CK(sr, 1'b0)
    r(8'h00, 8'h82);
    w(8'h00, 8'haa);
    #1 `CK(rs, 1'b0)
  endtask
  task finish_test;
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    r(8'h00, 8'h82);
    t_src;
    t_bus;
    t_gate;
    t_rst;
    finish_test;
  end
  initial begin
    repeat (1000) @(posedge ref_clk);
    error_cnt++;
    finish_test;
  end
endmodule // rss_reset_source_status_tb
bind rss_reset_source_status rss_checker rss_checker_i(.*);
